// >>> rtl/pio_pkg.sv
// constants and state type for the programmable i/o port bank
package pio_pkg;
  localparam int NPORT       = 11;
  localparam int PW          = 8;
  localparam int NPIN        = 88;
  localparam int NGRP        = 22;
  localparam int GRP_SH      = 2;
  localparam int PIN_IN_ONLY = 69;
  localparam int PIN_OD_A    = 57;
  localparam int PIN_OD_B    = 73;
  localparam int RB_PORT     = 1;
  localparam int AW          = 8;
  localparam int IW          = 6;

  localparam logic [IW-1:0] IDX_DIR0 = 6'h00;
  localparam logic [IW-1:0] IDX_DAT0 = 6'h10;
  localparam logic [IW-1:0] IDX_PU   = 6'h20;
  localparam logic [IW-1:0] IDX_PCTL = 6'h21;
  localparam logic [IW-1:0] IDX_MODE = 6'h22;

  localparam int MODE_W    = 4;
  localparam int MODE_BUS8 = 2;
  localparam int MODE_MUXF = 3;
  localparam logic [1:0] PM_MEMEXP = 2'h1;
  localparam logic [1:0] PM_MICRO  = 2'h2;

  localparam logic [NPIN-1:0] BUS_DIR_MASK = {40'h0, 48'hffffffffffff};
  localparam logic [NGRP-1:0] PU_BUS_MASK  = 22'h000dff;
  localparam logic [NPIN-1:0] ONE_PIN      = 88'h1;
  localparam logic [NPIN-1:0] NORM_MASK    =
    ~((ONE_PIN << PIN_IN_ONLY) | (ONE_PIN << PIN_OD_A) | (ONE_PIN << PIN_OD_B));

  localparam logic [NPIN-1:0]   DIR_RST  = 88'h0;
  localparam logic [NPIN-1:0]   LAT_RST  = 88'h0;
  localparam logic [NGRP-1:0]   PU_RST   = 22'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [NPIN-1:0]   dir;
    logic [NPIN-1:0]   lat;
    logic [NPIN-1:0]   s1;
    logic [NPIN-1:0]   s2;
    logic [NPIN-1:0]   po;
    logic [NPIN-1:0]   poe;
    logic [NPIN-1:0]   ppu;
    logic [NGRP-1:0]   pu;
    logic              pctl;
    logic [MODE_W-1:0] mode;
    logic              awv;
    logic [AW-1:0]     awa;
    logic              awr;
    logic              wv;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              wr;
    logic              bv;
    logic [1:0]        br;
    logic              arr;
    logic              rv;
    logic [31:0]       rd;
    logic [1:0]        rr;
  } pio_st_t;
endpackage

// >>> rtl/pio_ports.sv
// programmable i/o port bank with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
module pio_ports
  import pio_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [AW-1:0]   awaddr,
  input  wire logic [2:0]      awprot,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [AW-1:0]   araddr,
  input  wire logic [2:0]      arprot,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  input  wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0]      pin_out,
  output logic [NPIN-1:0]      pin_oe,
  output logic [NPIN-1:0]      pin_pu,
  input  wire logic [NPIN-1:0] periph_oe,
  input  wire logic [NPIN-1:0] periph_out
);

  pio_st_t         st_ff;
  pio_st_t         nxt_st;
  logic            ext;
  logic            rb_live;
  logic            wr_go;
  logic [IW-1:0]   widx;
  logic [IW-1:0]   ridx;
  logic [NPIN-1:0] wr_port_mask;
  logic [NPIN-1:0] pu_exp;
  logic [NPIN-1:0] pu_bus_pins;
  logic            drv;
  logic            val;
  int              p;
  int              k;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st       = st_ff;
    wr_go        = 1'b0;
    wr_port_mask = '0;
    pu_exp       = '0;
    pu_bus_pins  = '0;
    drv          = 1'b0;
    val          = 1'b0;
    p            = 0;
    k            = 0;
    ext   = (st_ff.mode[1:0] == PM_MEMEXP) || (st_ff.mode[1:0] == PM_MICRO);
    rb_live = (ext && st_ff.mode[MODE_BUS8]) || st_ff.mode[MODE_MUXF];
    widx    = st_ff.awa[AW-1:2];
    ridx    = araddr[AW-1:2];
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;

    // write address and data are taken in either order
    if (awvalid && st_ff.awr) begin
      nxt_st.awv = 1'b1;
      nxt_st.awa = awaddr;
    end
    if (wvalid && st_ff.wr) begin
      nxt_st.wv = 1'b1;
      nxt_st.wd = wdata;
      nxt_st.ws = wstrb;
    end
    if (st_ff.bv && bready) begin
      nxt_st.bv = 1'b0;
    end
    if (st_ff.awv && st_ff.wv && !st_ff.bv) begin
      wr_go      = 1'b1;
      nxt_st.awv = 1'b0;
      nxt_st.wv  = 1'b0;
      nxt_st.bv  = 1'b1;
      nxt_st.br  = RESP_OKAY;
      if (widx >= IDX_DIR0 && widx < IDX_DIR0 + IW'(NPORT)) begin
        p = int'(widx - IDX_DIR0);
        wr_port_mask = {{(NPIN-PW){1'b0}}, {PW{1'b1}}} << (p * PW);
        for (int j = 0; j < PW; j++) begin
          k = p * PW + j;
          // input-only pin has no direction bit
          if (st_ff.ws[0] && !(ext && BUS_DIR_MASK[k]) && k != PIN_IN_ONLY) begin
            nxt_st.dir[k] = st_ff.wd[j];
          end
        end
      end else if (widx >= IDX_DAT0 && widx < IDX_DAT0 + IW'(NPORT)) begin
        p = int'(widx - IDX_DAT0);
        if (st_ff.ws[0]) begin
          nxt_st.lat[p*PW +: PW] = st_ff.wd[PW-1:0];
        end
      end else if (widx == IDX_PU) begin
        for (int g = 0; g < NGRP; g++) begin
          if (st_ff.ws[g/8]) begin
            nxt_st.pu[g] = st_ff.wd[g];
          end
        end
      end else if (widx == IDX_PCTL) begin
        if (st_ff.ws[0]) begin
          nxt_st.pctl = st_ff.wd[0];
        end
      end else if (widx == IDX_MODE) begin
        if (st_ff.ws[0]) begin
          nxt_st.mode = st_ff.wd[MODE_W-1:0];
        end
      end else begin
        nxt_st.br = RESP_SLVERR;
      end
    end
    nxt_st.awr = !nxt_st.awv && !nxt_st.bv;
    nxt_st.wr  = !nxt_st.wv && !nxt_st.bv;

    // read channel
    if (st_ff.rv && rready) begin
      nxt_st.rv = 1'b0;
    end
    if (arvalid && st_ff.arr) begin
      nxt_st.rv = 1'b1;
      nxt_st.rd = 32'h0;
      nxt_st.rr = RESP_OKAY;
      if (ridx >= IDX_DIR0 && ridx < IDX_DIR0 + IW'(NPORT)) begin
        p = int'(ridx - IDX_DIR0);
        nxt_st.rd[PW-1:0] = st_ff.dir[p*PW +: PW];
      end else if (ridx >= IDX_DAT0 && ridx < IDX_DAT0 + IW'(NPORT)) begin
        p = int'(ridx - IDX_DAT0);
        for (int j = 0; j < PW; j++) begin
          k   = p * PW + j;
          drv = st_ff.dir[k] | periph_oe[k];
          if ((rb_live && st_ff.pctl && p == RB_PORT) || (drv && k != PIN_IN_ONLY)) begin
            nxt_st.rd[j] = st_ff.lat[k];
          end else begin
            nxt_st.rd[j] = st_ff.s2[k];
          end
        end
      end else if (ridx == IDX_PU) begin
        nxt_st.rd[NGRP-1:0] = st_ff.pu;
      end else if (ridx == IDX_PCTL) begin
        nxt_st.rd[0] = st_ff.pctl;
      end else if (ridx == IDX_MODE) begin
        nxt_st.rd[MODE_W-1:0] = st_ff.mode;
      end else begin
        nxt_st.rr = RESP_SLVERR;
      end
    end
    nxt_st.arr = !nxt_st.rv;

    // pin drivers follow the state being registered
    for (int i = 0; i < NPIN; i++) begin
      drv = nxt_st.dir[i] | periph_oe[i];
      val = periph_oe[i] ? periph_out[i] : nxt_st.lat[i];
      pu_exp[i]      = st_ff.pu[i >> GRP_SH];
      pu_bus_pins[i] = PU_BUS_MASK[i >> GRP_SH];
      if (i == PIN_IN_ONLY) begin
        nxt_st.po[i]  = 1'b0;
        nxt_st.poe[i] = 1'b0;
        nxt_st.ppu[i] = 1'b0;
      end else if (i == PIN_OD_A || i == PIN_OD_B) begin
        nxt_st.po[i]  = 1'b0;
        nxt_st.poe[i] = drv & ~val;
        nxt_st.ppu[i] = 1'b0;
      end else begin
        nxt_st.po[i]  = val;
        nxt_st.poe[i] = drv;
        nxt_st.ppu[i] = nxt_st.pu[i >> GRP_SH] & ~drv
                      & ~((nxt_st.mode[1:0] == PM_MEMEXP || nxt_st.mode[1:0] == PM_MICRO)
                          && PU_BUS_MASK[i >> GRP_SH]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff      <= '0;
      st_ff.dir  <= DIR_RST;
      st_ff.lat  <= LAT_RST;
      st_ff.pu   <= PU_RST;
      st_ff.mode <= MODE_RST;
      st_ff.awr  <= 1'b1;
      st_ff.wr   <= 1'b1;
      st_ff.arr  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awr;
  assign wready  = st_ff.wr;
  assign bvalid  = st_ff.bv;
  assign bresp   = st_ff.br;
  assign arready = st_ff.arr;
  assign rvalid  = st_ff.rv;
  assign rdata   = st_ff.rd;
  assign rresp   = st_ff.rr;
  assign pin_out = st_ff.po;
  assign pin_oe  = st_ff.poe;
  assign pin_pu  = st_ff.ppu;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_in_only_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_oe[PIN_IN_ONLY] && !pin_pu[PIN_IN_ONLY] && !st_ff.dir[PIN_IN_ONLY])
    else $error("input-only pin driven or pulled");

  a_od_low_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_out[PIN_OD_A] && !pin_out[PIN_OD_B] && !pin_pu[PIN_OD_A] && !pin_pu[PIN_OD_B])
    else $error("open-drain pin driven high or pulled");

  a_pu_input_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_pu & (st_ff.dir | pin_oe)) == '0)
    else $error("pull-up on an output pin");

  a_pu_group_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (pin_pu & ~pu_exp) == '0 && ((pu_exp & ~st_ff.dir & NORM_MASK
      & ~($past(periph_oe)) & ~(ext ? pu_bus_pins : '0)) & ~pin_pu) == '0)
    else $error("pull-up disagrees with its group bit");

  a_periph_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ($past(periph_oe) & NORM_MASK & ~pin_oe) == '0)
    else $error("peripheral output pin not driven");

  a_reset_inputs: assert property (@(posedge aclk)
    !aresetn |=> pin_oe == '0 && pin_pu == '0 && st_ff.dir == '0)
    else $error("pins not idle after reset");

  a_dir_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    ext |=> ((st_ff.dir ^ $past(st_ff.dir)) & BUS_DIR_MASK) == '0)
    else $error("bus pin direction changed in external mode");

  a_dir_own_port: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> ((st_ff.dir ^ $past(st_ff.dir)) & ~$past(wr_port_mask)) == '0)
    else $error("direction write touched another port");

  a_pu_bus_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ext |-> (pin_pu & pu_bus_pins) == '0)
    else $error("bus-side pull-up applied in external mode");

  a_latch_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((pin_out ^ st_ff.lat) & st_ff.dir & ~$past(periph_oe)
      & NORM_MASK) == '0)
    else $error("output pin not showing its latch");

  a_rb_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && rb_live && st_ff.pctl
      && araddr[AW-1:2] == IDX_DAT0 + IW'(RB_PORT)
    |=> rdata[PW-1:0] == $past(st_ff.lat[RB_PORT*PW +: PW]))
    else $error("port one select did not return latch");

  a_sync_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(aresetn, 2) |-> st_ff.s2 == $past(pin_in, 2))
    else $error("pin sample not two stages deep");

endmodule
`default_nettype wire

// >>> tb/pio_pin_model.sv
// pad-side model: resolves each pin from device drive, outside drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model
  import pio_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] pin_pu,
  input  wire logic [NPIN-1:0] ext_en,
  input  wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0]      pin_in
);
  logic [NPIN-1:0] lvl = '0;

  assign pin_in = lvl;

  ////////////////////////////////////////
  // a pad nobody drives or pulls floats, shown as a level that flips every cycle
  always @(posedge aclk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (pin_oe[i])
        lvl[i] <= pin_out[i];
      else if (ext_en[i])
        lvl[i] <= ext_val[i];
      else if (pin_pu[i])
        lvl[i] <= 1'b1;
      else
        lvl[i] <= ~lvl[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the programmable i/o port bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pio_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic [AW-1:0]   awaddr = '0;
  logic [AW-1:0]   araddr = '0;
  logic            awvalid = 1'b0;
  logic            wvalid = 1'b0;
  logic            bready = 1'b0;
  logic            arvalid = 1'b0;
  logic            rready = 1'b0;
  logic [31:0]     wdata = '0;
  logic [3:0]      wstrb = '0;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [31:0]     rdata;
  logic [1:0]      bresp, rresp, rsp;
  logic [31:0]     rv;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [NPIN-1:0] periph_oe = '0;
  logic [NPIN-1:0] periph_out = '0;
  logic [NPIN-1:0] ext_en = '0;
  logic [NPIN-1:0] ext_val = '0;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              cyc = 0;

  pio_ports i_pio_ports (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe,
    .pin_pu, .periph_oe, .periph_out);
  pio_pin_model i_pio_pin_model (.aclk, .pin_out, .pin_oe, .pin_pu, .ext_en, .ext_val,
    .pin_in);

  always #5 aclk = ~aclk;

  ////////////////////////////////////////
  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input logic [NPIN-1:0] g, input logic [NPIN-1:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(NPIN'(rv), NPIN'(e));
    chk(NPIN'(rsp), NPIN'(RESP_OKAY));
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pin_oe, '0);
    chk(pin_pu, '0);
    rc(8'h00, 32'h0);
    wr(8'h00, 32'h5a);
    chk(rsp, RESP_OKAY);
    wr(8'h40, 32'hf5);
    chk(pin_oe, 88'h5a);
    chk(pin_out & pin_oe, 88'h50);
    @(posedge aclk);
    ext_en <= 88'hff;
    ext_val <= 88'h0f;
    repeat (3) @(posedge aclk);
    rc(8'h40, 32'h55);
    wr(8'h80, 32'h3fffff);
    chk(pin_pu, ~88'h5a & NORM_MASK);
    wr(8'h80, 32'h2);
    chk(pin_pu, 88'ha0);
    wr(8'h20, 32'hff);
    rc(8'h20, 32'hdf);
    chk(pin_oe, 88'h5a | (88'hdf << 64));
    for (int p = 7; p <= 9; p += 2) begin
      wr(8'(4 * p), 32'h2);
      wr(8'(64 + 4 * p), 32'h0);
      chk(pin_oe[p * 8 + 1], 1'b1);
      wr(8'(64 + 4 * p), 32'h2);
      chk(pin_oe[p * 8 + 1], 1'b0);
      chk(pin_out[p * 8 + 1], 1'b0);
    end
    // a peripheral output claims pin 16 even with its direction bit clear
    @(posedge aclk);
    periph_oe[16] <= 1'b1;
    periph_out[16] <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(pin_oe[16], 1'b1);
    chk(pin_out[16], 1'b1);
    wr(8'h04, 32'h0f);
    wr(8'h44, 32'h33);
    @(posedge aclk);
    ext_en <= 88'hffff;
    wr(8'h84, 32'h1);
    repeat (3) @(posedge aclk);
    rc(8'h44, 32'h03);
    wr(8'h88, 32'h5);
    rc(8'h44, 32'h33);
    wr(8'h84, 32'h0);
    rc(8'h44, 32'h03);
    wr(8'h88, 32'ha);
    wr(8'h84, 32'h1);
    rc(8'h44, 32'h33);
    wr(8'h00, 32'hff);
    rc(8'h00, 32'h5a);
    wr(8'h18, 32'h01);
    rc(8'h18, 32'h01);
    wr(8'h80, 32'h3fffff);
    rc(8'h80, 32'h3fffff);
    chk(pin_pu & {40'h0, {48{1'b1}}}, 88'hf000000000);
    chk(pin_pu[55:48], 8'hfe);
    // mid-run reset must return every pin to an undriven input
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pin_oe, '0);
    chk(pin_pu, '0);
    rc(8'h88, 32'h0);
    wr(8'h90, 32'h1);
    chk(rsp, RESP_SLVERR);
    rd(8'h90);
    chk(rv, 32'h0);
    chk(rsp, RESP_SLVERR);
    give_verdict();
  end
endmodule
`default_nettype wire
